/* File: core/ptb_timebase.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ptb_timebase
    import ptb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial port shift clock source
    output logic ssp_match_pulse,
    // Bridge outputs and interrupt
    output ptb_out_t bridge_out,
    output logic irq
);
    ptb_state_t s_q, s_d;
    logic wr, rd, hit;
    logic [7:0] idx, wv, rv;
    logic tick, pwm_mode, base_match;
    logic acc, addr_ok, setup_rd, run, post_hit, flag_src;
    logic [3:0] a_b_c_d;

    assign idx = paddr[9:2];
    assign wv = pwdata[7:0];
    // Refused accesses neither write nor clear anything
    assign acc = psel && penable;
    assign wr = acc && pwrite && addr_ok;
    assign rd = acc && !pwrite && addr_ok;
    assign setup_rd = psel && !penable && !pwrite;
    assign run = s_q.tb_ctrl[PTB_TBC_ON_BIT];
    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign irq = |(s_q.irq_flags & s_q.irq_en);
    assign ssp_match_pulse = s_q.match;
    assign pwm_mode = s_q.ccp_ctrl[3:2] == PTB_MODE_PWM;

    always_comb begin
        unique case (idx)
            PTB_OFF_IRQ_FLAGS, PTB_OFF_COUNT, PTB_OFF_TB_CTRL, PTB_OFF_DUTY_LOW,
            PTB_OFF_DUTY_HIGH, PTB_OFF_CCP_CTRL, PTB_OFF_DEADBAND, PTB_OFF_IRQ_EN,
            PTB_OFF_PERIOD: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    // Upper address bits are decoded too, so no register shows up twice
    assign addr_ok = hit && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
    assign pslverr = acc && !addr_ok;

    // Prescaler tick: divide 1, 4 or 16
    always_comb begin
        unique case (s_q.tb_ctrl[1:0])
            PTB_PS_DIV1: tick = 1'b1;
            PTB_PS_DIV4: tick = s_q.pre_cnt[1:0] == PTB_PRE4_LAST[1:0];
            default: tick = s_q.pre_cnt == PTB_PRE16_LAST;
        endcase
    end
    assign base_match = s_q.tb_ctrl[PTB_TBC_ON_BIT] && tick && s_q.count == s_q.period;
    assign post_hit = base_match && s_q.post_cnt == s_q.tb_ctrl[6:PTB_TBC_POST_LSB];
    assign flag_src = post_hit || (wr && idx == PTB_OFF_IRQ_FLAGS && wv[PTB_FLAG_BIT]);

    always_comb begin
        rv = 8'h00;
        unique case (idx)
            PTB_OFF_IRQ_FLAGS: rv = s_q.irq_flags;
            PTB_OFF_COUNT: rv = s_q.count;
            PTB_OFF_TB_CTRL: rv = s_q.tb_ctrl;
            PTB_OFF_DUTY_LOW: rv = s_q.duty_low;
            PTB_OFF_DUTY_HIGH: rv = s_q.duty_high;
            PTB_OFF_CCP_CTRL: rv = s_q.ccp_ctrl;
            PTB_OFF_DEADBAND: rv = s_q.deadband;
            PTB_OFF_IRQ_EN: rv = s_q.irq_en;
            PTB_OFF_PERIOD: rv = s_q.period;
            default: rv = 8'h00;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.match = 1'b0;
        // Latched in the setup cycle so the data stands at the access edge
        s_d.prdata = setup_rd ? {24'h0, addr_ok ? rv : 8'h00} : s_q.prdata;
        // Counter runs only while enabled; stopping it saves power
        if (s_q.tb_ctrl[PTB_TBC_ON_BIT]) begin
            s_d.pre_cnt = s_q.pre_cnt + 4'h1;
            if (tick) begin
                s_d.pre_cnt = 4'h0;
                if (base_match) begin
                    s_d.count = PTB_RST_ZERO;
                    s_d.match = 1'b1;
                    s_d.post_cnt = s_q.post_cnt + 4'h1;
                    if (s_q.post_cnt == s_q.tb_ctrl[6:PTB_TBC_POST_LSB]) begin
                        s_d.post_cnt = 4'h0;
                        s_d.irq_flags[PTB_FLAG_BIT] = 1'b1;
                    end
                end else begin
                    s_d.count = s_q.count + 8'h01;
                end
            end
        end
        // PWM: 10-bit cycle from count and prescaler position
        s_d.pwm_cnt = {s_q.count, s_q.pre_cnt[1:0]};
        if (base_match) begin
            s_d.duty_act = {s_q.duty_low, s_q.ccp_ctrl[5:4]};
        end
        s_d.pwm_raw = pwm_mode && (s_d.pwm_cnt < s_q.duty_act);
        // Deadband: delay the rising edge of each half of the pair
        if (s_q.pwm_raw != s_d.pwm_raw) begin
            s_d.dead_cnt = s_q.deadband;
            s_d.pwm_a = 1'b0;
            s_d.pwm_b = 1'b0;
        end else if (s_q.dead_cnt != 8'h00) begin
            s_d.dead_cnt = s_q.dead_cnt - 8'h01;
        end else begin
            s_d.pwm_a = s_q.pwm_raw;
            s_d.pwm_b = !s_q.pwm_raw;
        end
        if (wr) begin
            unique case (idx)
                PTB_OFF_COUNT: begin
                    s_d.count = wv;
                    s_d.pre_cnt = 4'h0;
                    s_d.post_cnt = 4'h0;
                end
                PTB_OFF_TB_CTRL: begin
                    s_d.tb_ctrl = wv & PTB_TBC_MASK;
                    s_d.pre_cnt = 4'h0;
                    s_d.post_cnt = 4'h0;
                end
                PTB_OFF_PERIOD: s_d.period = wv;
                PTB_OFF_DUTY_LOW: s_d.duty_low = wv;
                PTB_OFF_DUTY_HIGH: s_d.duty_high = wv;
                PTB_OFF_CCP_CTRL: s_d.ccp_ctrl = wv;
                PTB_OFF_DEADBAND: s_d.deadband = wv;
                PTB_OFF_IRQ_EN: s_d.irq_en = wv & PTB_IRQ_MASK;
                default: s_d.count = s_d.count;
            endcase
        end
        // Read clears, but a flag set in the same cycle survives
        // Only bits already reported to the reader are cleared
        if (rd && idx == PTB_OFF_IRQ_FLAGS) begin
            s_d.irq_flags = s_q.irq_flags & ~s_q.prdata[7:0];
            if (post_hit) begin
                s_d.irq_flags[PTB_FLAG_BIT] = 1'b1;
            end
        end
        if (wr && idx == PTB_OFF_IRQ_FLAGS) begin
            s_d.irq_flags[PTB_FLAG_BIT] = wv[PTB_FLAG_BIT] | s_d.irq_flags[PTB_FLAG_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.period <= PTB_RST_PERIOD;
            s_q.ccp_ctrl <= PTB_RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // Pins: drive bit set means the unit owns the pin, else port pin
    always_comb begin
        a_b_c_d = 4'h0;
        bridge_out.drive = 4'h0;
        if (!pwm_mode) begin
            bridge_out.drive = {3'h0, s_q.ccp_ctrl[3:0] != 4'h0};
        end else begin
            unique case (s_q.ccp_ctrl[7:6])
                2'h0: begin
                    bridge_out.drive = 4'h1;
                    a_b_c_d = {3'h0, s_q.pwm_raw};
                end
                2'h1: begin
                    bridge_out.drive = 4'hf;
                    a_b_c_d = {s_q.pwm_raw, 2'h0, 1'b1};
                end
                2'h2: begin
                    bridge_out.drive = 4'h3;
                    a_b_c_d = {2'h0, s_q.pwm_b, s_q.pwm_a};
                end
                default: begin
                    bridge_out.drive = 4'hf;
                    a_b_c_d = {1'b0, 1'b1, s_q.pwm_raw, 1'b0};
                end
            endcase
        end
        bridge_out.level = a_b_c_d;
    end

    a_period_reset: assert property (@(posedge clk) sys_rst |=> s_q.period == 8'hff)
        else $error("period not all ones after reset");
    a_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        base_match && !wr |=> s_q.count == 8'h00)
        else $error("counter did not wrap");
    a_match_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        base_match |=> ssp_match_pulse)
        else $error("match pulse missing");
    a_halt_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.tb_ctrl[2] && !wr |=> $stable(s_q.count))
        else $error("counter moved while off");
    a_ctrl_clear: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_TB_CTRL |=> s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0)
        else $error("scalers not cleared");
    a_fwd_pins: assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.ccp_ctrl[7:6] == 2'h1 |-> bridge_out.level[2:0] == 3'h1)
        else $error("forward bridge levels wrong");
    a_rev_pins: assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.ccp_ctrl[7:6] == 2'h3 |-> bridge_out.level[3:2] == 2'h1
        && !bridge_out.level[0])
        else $error("reverse bridge levels wrong");
    a_nonpwm_pins: assert property (@(posedge clk) disable iff (sys_rst)
        !pwm_mode |-> bridge_out.drive[3:1] == 3'h0)
        else $error("port pins taken outside pwm");
    a_half_excl: assert property (@(posedge clk) disable iff (sys_rst)
        !(s_q.pwm_a && s_q.pwm_b))
        else $error("half bridge overlap");
    c_match: cover property (@(posedge clk) ssp_match_pulse);
    c_irq: cover property (@(posedge clk) irq);
    c_half: cover property (@(posedge clk) pwm_mode && s_q.ccp_ctrl[7:6] == 2'h2 && s_q.pwm_b);
    c_fwd: cover property (@(posedge clk) pwm_mode && s_q.ccp_ctrl[7:6] == 2'h1);
    c_rd_clr: cover property (@(posedge clk) rd && idx == PTB_OFF_IRQ_FLAGS && s_q.irq_flags[1]);

    // Reset state
    a_reset_zero: assert property (@(posedge clk) sys_rst |=> s_q.count == 8'h00
        && s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0 && s_q.irq_flags == 8'h00)
        else $error("state not cleared by reset");

    a_reset_ccp: assert property (@(posedge clk) sys_rst |=> s_q.ccp_ctrl == 8'h00
        && bridge_out.drive == 4'h0)
        else $error("unit control not cleared by reset");

    // Counter and prescaler
    a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
        run && tick && !base_match && !wr |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step");

    a_notick_hold: assert property (@(posedge clk) disable iff (sys_rst)
        run && !tick && !wr |=> $stable(s_q.count))
        else $error("counter moved without tick");

    a_div1_tick: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.tb_ctrl[1:0] == PTB_PS_DIV1 |-> tick)
        else $error("divide by one missed a tick");

    a_div4_tick: assert property (@(posedge clk) disable iff (sys_rst)
        tick && s_q.tb_ctrl[1:0] == PTB_PS_DIV4 |-> s_q.pre_cnt[1:0] == 2'h3)
        else $error("divide by four ticked early");

    a_div16_tick: assert property (@(posedge clk) disable iff (sys_rst)
        tick && s_q.tb_ctrl[1] |-> s_q.pre_cnt == PTB_PRE16_LAST)
        else $error("divide by sixteen ticked early");

    a_pre_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        run && tick && !wr |=> s_q.pre_cnt == 4'h0)
        else $error("prescaler did not wrap");

    a_pre_step: assert property (@(posedge clk) disable iff (sys_rst)
        run && !tick && !wr |=> s_q.pre_cnt == $past(s_q.pre_cnt) + 4'h1)
        else $error("prescaler did not step");

    a_count_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_COUNT |=> s_q.count == $past(wv)
        && s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0)
        else $error("count write not applied");

    a_ctrl_keep: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_TB_CTRL && !run |=> $stable(s_q.count))
        else $error("control write changed counter");

    a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_TB_CTRL |=> s_q.tb_ctrl == ($past(wv) & PTB_TBC_MASK))
        else $error("control write not applied");

    a_halt_pre: assert property (@(posedge clk) disable iff (sys_rst)
        !run && !wr |=> $stable(s_q.pre_cnt))
        else $error("prescaler moved while off");

    a_halt_match: assert property (@(posedge clk) disable iff (sys_rst)
        !run |-> !base_match)
        else $error("match while off");

    a_match_src: assert property (@(posedge clk) disable iff (sys_rst)
        ssp_match_pulse |-> $past(base_match))
        else $error("match pulse without match");

    // Postscaler, flag and interrupt
    a_post_step: assert property (@(posedge clk) disable iff (sys_rst)
        base_match && !post_hit && !wr |=> s_q.post_cnt == $past(s_q.post_cnt) + 4'h1)
        else $error("postscaler did not step");

    a_post_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        post_hit && !wr |=> s_q.post_cnt == 4'h0)
        else $error("postscaler did not wrap");

    a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        post_hit |=> s_q.irq_flags[PTB_FLAG_BIT])
        else $error("flag not set by postscaled match");

    a_flag_source: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s_q.irq_flags[PTB_FLAG_BIT]) |-> $past(flag_src))
        else $error("flag set without cause");

    a_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
        rd && idx == PTB_OFF_IRQ_FLAGS && !post_hit
        |=> (s_q.irq_flags & $past(s_q.prdata[7:0])) == 8'h00)
        else $error("reported flags not cleared");

    a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.irq_en == 8'h00 |-> !irq)
        else $error("interrupt while masked");

    a_irq_raise: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.irq_en[PTB_FLAG_BIT] && s_q.irq_flags[PTB_FLAG_BIT] |-> irq)
        else $error("interrupt missing");

    a_en_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_IRQ_EN |=> s_q.irq_en == ($past(wv) & PTB_IRQ_MASK))
        else $error("enable write not applied");

    // Register bus
    a_period_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_PERIOD |=> s_q.period == $past(wv))
        else $error("period write not applied");

    a_period_read: assert property (@(posedge clk) disable iff (sys_rst)
        setup_rd && addr_ok && idx == PTB_OFF_PERIOD |=> prdata == {24'h0, $past(s_q.period)})
        else $error("period read data wrong");

    a_refused_wr: assert property (@(posedge clk) disable iff (sys_rst)
        acc && !addr_ok |=> $stable(s_q.period) && $stable(s_q.tb_ctrl)
        && $stable(s_q.ccp_ctrl) && $stable(s_q.irq_en))
        else $error("refused access changed a register");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        setup_rd && !addr_ok |=> prdata == 32'h0)
        else $error("unmapped read not zero");

    a_prdata_upper: assert property (@(posedge clk) disable iff (sys_rst)
        prdata[31:8] == 24'h0)
        else $error("upper read data not zero");

    a_duty_low_wr: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_DUTY_LOW |=> s_q.duty_low == $past(wv))
        else $error("duty low write not applied");

    a_duty_high_wr: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_DUTY_HIGH |=> s_q.duty_high == $past(wv))
        else $error("duty high write not applied");

    a_ccp_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_CCP_CTRL |=> s_q.ccp_ctrl == $past(wv))
        else $error("unit control write not applied");

    a_dead_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr && idx == PTB_OFF_DEADBAND |=> s_q.deadband == $past(wv))
        else $error("deadband write not applied");

    // Modulation and pins
    a_duty_latch: assert property (@(posedge clk) disable iff (sys_rst)
        base_match |=> s_q.duty_act == {$past(s_q.duty_low), $past(s_q.ccp_ctrl[5:4])})
        else $error("duty not latched at match");

    a_pwm_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !pwm_mode |=> !s_q.pwm_raw)
        else $error("modulation outside pwm mode");

    a_single_pins: assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.ccp_ctrl[7:6] == 2'h0 |-> bridge_out.drive == 4'h1
        && bridge_out.level[3:1] == 3'h0)
        else $error("single output pins wrong");

    a_half_pins: assert property (@(posedge clk) disable iff (sys_rst)
        pwm_mode && s_q.ccp_ctrl[7:6] == 2'h2 |-> bridge_out.drive == 4'h3
        && bridge_out.level[3:2] == 2'h0)
        else $error("half bridge pins wrong");

    a_dead_start: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(s_q.pwm_raw) |-> !s_q.pwm_a && !s_q.pwm_b)
        else $error("no dead time at edge");

    // Released pins always rest low
    for (genvar p = 0; p < 4; p++) begin : g_pin
        a_port_low: assert property (@(posedge clk) disable iff (sys_rst)
            !bridge_out.drive[p] |-> !bridge_out.level[p])
            else $error("released pin not low");
    end
endmodule // ptb_timebase
`default_nettype wire

/* File: dv/period_timebase_and_bridge_output_config_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module period_timebase_and_bridge_output_config_tb
    import ptb_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ssp_match_pulse;
    ptb_out_t bridge_out;
    logic irq;
    logic shift_clk;
    int fail_count = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [31:0] keep;
    logic err;
    int n;
    // Mode, drive mask, drive expected, level mask, level expected
    logic [23:0] tbl [5] = '{24'h08e000, 24'h0cf100, 24'h4cff71, 24'h8cf300, 24'hccffd4};

    always #12.5 clk = ~clk;

    ptb_timebase i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ssp_match_pulse(ssp_match_pulse), .bridge_out(bridge_out),
        .irq(irq));

    ptb_far_model i_far (.clk(clk), .sys_rst(sys_rst), .ssp_match_pulse(ssp_match_pulse),
        .shift_clk(shift_clk));

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // Read data is taken at the access edge; one idle edge follows the release
    task automatic apb(input logic wr, input logic [7:0] off, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, off, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k >= 100) begin
            fail_count++;
            give_verdict();
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input string name, input logic [7:0] off, input logic [31:0] exp);
        apb(1'b0, off, 8'h00);
        chk(name, exp, rd);
    endtask

    // Cycles between two toggles of the shift clock
    task automatic gap(output int c);
        logic s;
        c = 0;
        @(negedge clk);
        s = shift_clk;
        while (shift_clk === s && c < 300) begin @(negedge clk); c++; end
        s = shift_clk;
        c = 0;
        while (shift_clk === s && c < 300) begin @(negedge clk); c++; end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rchk("period_rst", PTB_OFF_PERIOD, 32'hff);
        rchk("count_rst", PTB_OFF_COUNT, 32'h0);
        rchk("ccp_rst", PTB_OFF_CCP_CTRL, 32'h0);
        chk("drive_rst", 32'h0, {28'h0, bridge_out.drive});
        apb(1'b1, PTB_OFF_PERIOD, 8'h5a);
        rchk("period_rw", PTB_OFF_PERIOD, 32'h5a);
        apb(1'b1, PTB_OFF_DUTY_LOW, 8'ha5);
        apb(1'b1, PTB_OFF_DUTY_HIGH, 8'h3c);
        apb(1'b1, PTB_OFF_DEADBAND, 8'h07);
        rchk("duty_low", PTB_OFF_DUTY_LOW, 32'ha5);
        rchk("duty_high", PTB_OFF_DUTY_HIGH, 32'h3c);
        rchk("deadband", PTB_OFF_DEADBAND, 32'h07);
        apb(1'b1, 8'h01, 8'h55);
        chk("unmapped_err", 32'h1, {31'h0, err});
        rchk("unmapped_rd", 8'h01, 32'h0);
        apb(1'b1, PTB_OFF_PERIOD, 8'h03);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, PTB_OFF_TB_CTRL, {6'h01, i[1:0]});
            gap(n);
            gap(n);
            chk("match_gap", 32'd4 << (2 * i), n);
        end
        apb(1'b1, PTB_OFF_TB_CTRL, 8'h00);
        rchk("ctrl_rw", PTB_OFF_TB_CTRL, 32'h0);
        apb(1'b0, PTB_OFF_COUNT, 8'h00);
        keep = rd;
        repeat (10) @(posedge clk);
        rchk("count_halt", PTB_OFF_COUNT, keep);
        apb(1'b1, PTB_OFF_IRQ_EN, 8'h02);
        apb(1'b1, PTB_OFF_TB_CTRL, 8'h0c);
        repeat (20) @(posedge clk);
        chk("irq_set", 32'h1, {31'h0, irq});
        apb(1'b1, PTB_OFF_TB_CTRL, 8'h00);
        rchk("flags_set", PTB_OFF_IRQ_FLAGS, 32'h2);
        rchk("flags_clr", PTB_OFF_IRQ_FLAGS, 32'h0);
        chk("irq_clr", 32'h0, {31'h0, irq});
        apb(1'b1, PTB_OFF_IRQ_EN, 8'h00);
        apb(1'b1, PTB_OFF_IRQ_FLAGS, 8'h02);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, PTB_OFF_IRQ_EN, 8'h02);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, PTB_OFF_COUNT, 8'h02);
        apb(1'b1, PTB_OFF_TB_CTRL, 8'h00);
        rchk("count_kept", PTB_OFF_COUNT, 32'h2);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, PTB_OFF_CCP_CTRL, tbl[i][23:16]);
            chk("drive", {28'h0, tbl[i][11:8]},
                {28'h0, bridge_out.drive & tbl[i][15:12]});
            chk("level", {28'h0, tbl[i][3:0]},
                {28'h0, bridge_out.level & tbl[i][7:4]});
        end
        apb(1'b1, PTB_OFF_DUTY_LOW, 8'h02);
        apb(1'b1, PTB_OFF_CCP_CTRL, 8'h2c);
        apb(1'b1, PTB_OFF_TB_CTRL, 8'h04);
        repeat (8) @(posedge clk);
        n = 0;
        repeat (8) begin
            @(negedge clk);
            if (bridge_out.level[0] === 1'b1) n++;
        end
        chk("duty_high_cycles", 32'd6, n);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule // period_timebase_and_bridge_output_config_tb
`default_nettype wire

/* File: dv/ptb_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ptb_far_model
    import ptb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Timebase side
    input wire logic ssp_match_pulse,
    // Serial port shift clock
    output logic shift_clk
);
    // Halving the match rate gives a square shift clock, as the serial port does
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_clk <= 1'b0;
        end else if (ssp_match_pulse) begin
            shift_clk <= ~shift_clk;
        end
    end
endmodule // ptb_far_model
`default_nettype wire

/* File: shared/ptb_pkg.sv */
package ptb_pkg;
    localparam logic [7:0] PTB_OFF_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] PTB_OFF_COUNT = 8'h11;
    localparam logic [7:0] PTB_OFF_TB_CTRL = 8'h12;
    localparam logic [7:0] PTB_OFF_DUTY_LOW = 8'h15;
    localparam logic [7:0] PTB_OFF_DUTY_HIGH = 8'h16;
    localparam logic [7:0] PTB_OFF_CCP_CTRL = 8'h17;
    localparam logic [7:0] PTB_OFF_DEADBAND = 8'h18;
    localparam logic [7:0] PTB_OFF_IRQ_EN = 8'h8c;
    localparam logic [7:0] PTB_OFF_PERIOD = 8'h92;
    localparam logic [7:0] PTB_RST_PERIOD = 8'hff;
    localparam logic [7:0] PTB_RST_ZERO = 8'h00;
    localparam int PTB_FLAG_BIT = 1;
    localparam int PTB_TBC_POST_LSB = 3;
    localparam int PTB_TBC_ON_BIT = 2;
    localparam logic [7:0] PTB_TBC_MASK = 8'h7f;
    localparam logic [7:0] PTB_IRQ_MASK = 8'h02;
    localparam logic [1:0] PTB_PS_DIV1 = 2'h0;
    localparam logic [1:0] PTB_PS_DIV4 = 2'h1;
    localparam logic [3:0] PTB_PRE4_LAST = 4'h3;
    localparam logic [3:0] PTB_PRE16_LAST = 4'hf;
    localparam logic [1:0] PTB_MODE_PWM = 2'h3;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
        logic [7:0] tb_ctrl;
        logic [7:0] ccp_ctrl;
        logic [7:0] duty_low;
        logic [7:0] duty_high;
        logic [7:0] deadband;
        logic [7:0] irq_flags;
        logic [7:0] irq_en;
        logic [3:0] pre_cnt;
        logic [3:0] post_cnt;
        logic match;
        logic [9:0] pwm_cnt;
        logic [9:0] duty_act;
        logic pwm_raw;
        logic [7:0] dead_cnt;
        logic pwm_a;
        logic pwm_b;
        logic [31:0] prdata;
    } ptb_state_t;

    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] level;
    } ptb_out_t;
endpackage
